/* pkg/cdb_pkg.sv */
// Constants, register map and carrier types for the comparator conditioning block
//==============================================================
// Overview of operation
// - Comparators 1-3 each have a debounce enable
// - Filtered output low when comparator off or below
// - Debounce change with output high raises interrupt
// - Four hysteresis enables in bits 3:0, reset 0
// - Eight-bit reference DAC code, reset zero
// - Select bit picks comparator 3 interrupt source
// - Bit 7 starts valley detection, reset 0
// - Delay code zero bypasses blanking delay
// - Code N delays 2(N-1) to 2N, saturating
//==============================================================
package cdb_pkg;

    //==============================================================
    // Timing
    localparam int CDB_CLK_HZ = 40_000_000; // System clock rate
    localparam int CDB_DBC_CLK_HZ = 8_000_000; // Debounce clock rate
    // Debounce tick divider, 40 MHz down to 8 MHz
    localparam int CDB_DBC_DIV = CDB_CLK_HZ / CDB_DBC_CLK_HZ;
    localparam int CDB_DBC_PERIODS = 3; // Ticks of stable input before output moves
    localparam int CDB_LEB_STEP_NS = 125; // One delay step, two 16 MHz cycles
    // Delay step in system cycles, rounded up
    localparam int CDB_LEB_STEP_CYC = (CDB_LEB_STEP_NS * (CDB_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CDB_LEB_SAT_STEPS = 48; // Saturated step count for codes 11xxxx

    //==============================================================
    // Register offsets (byte addresses)
    localparam int CDB_ADDR_W = 5;
    localparam logic [4:0] CDB_OFS_FILT = 5'h00; // comparator_filter_enable
    localparam logic [4:0] CDB_OFS_HYST = 5'h04; // comparator_hysteresis_enable
    localparam logic [4:0] CDB_OFS_DAC = 5'h08; // cmp3_reference_dac_code
    localparam logic [4:0] CDB_OFS_LEB = 5'h0C; // cmp3_blanking_control
    localparam logic [4:0] CDB_OFS_CEN = 5'h10; // Comparator enables
    localparam logic [4:0] CDB_OFS_STAT = 5'h14; // Interrupt status, write one to clear
    localparam logic [4:0] CDB_OFS_MASK = 5'h18; // Interrupt mask
    localparam logic [4:0] CDB_OFS_LIVE = 5'h1C; // Live conditioned outputs

    //==============================================================
    // Field positions and reset values
    localparam int CDB_FILT_LSB = 5; // Filter enables sit in bits 7:5, a..c
    localparam int CDB_LEB_START_BIT = 7;
    localparam int CDB_LEB_SEL_BIT = 6;
    localparam logic [7:0] CDB_RST_BYTE = 8'h00; // All documented registers reset to zero
    localparam logic [1:0] CDB_RESP_OK = 2'h0;
    localparam logic [1:0] CDB_RESP_DECERR = 2'h3;
    localparam int CDB_NCMP = 3; // Debounced comparators a, b, c

    // Analog-facing control bundle
    typedef struct packed {
        logic [7:0] cmp3_reference_dac_code;
        logic cmp_c_hyst_en;
        logic cmp_b_hyst_en;
        logic cmp_a_hyst_en;
        logic cmp_z_hyst_en;
    } cdb_analog_t;

    // Blanking control register layout
    typedef struct packed {
        logic valley_detect_start;
        logic cmp_c_irq_source_sel;
        logic [5:0] blanking_delay_code;
    } cdb_leb_t;

endpackage : cdb_pkg

/* verification/cdb_cmp_model.sv */
// Behavioural model of the three analog comparator outputs
`timescale 1ns/1ps
`default_nettype none
module cdb_cmp_model (
    input wire logic aclk,
    input wire logic [2:0] want, // Levels the bench asks the comparators to show
    input wire logic slow, // Settle one cycle late, like a weakly overdriven input
    output logic cmp_a_out,
    output logic cmp_b_out,
    output logic cmp_c_out
);
    //====================================================
    // Output stage
    logic [2:0] lag_r; // Late copy used in slow mode
    // The raw pins are asynchronous to aclk, so late settling must not matter
    always_ff @(posedge aclk) begin
        lag_r <= want;
    end
    assign {cmp_c_out, cmp_b_out, cmp_a_out} = slow ? lag_r : want;
endmodule : cdb_cmp_model
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the comparator conditioning block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cdb_pkg::*;
    //====================================================
    // Clock, reset, bus and comparator signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0; // Held low for the first 8 cycles
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, ca, cb, cc;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    logic [2:0] want = 3'h0, irqv;
    logic slow = 1'b0;
    logic ce = 1'b1; // Clock enable, dropped once to check the freeze
    logic [7:0] d, e;
    logic [5:0] codes [7]; // Blanking delay codes, edges of the range included
    cdb_analog_t actl;
    int fails = 0;
    int checks_done = 0;
    int n, l0, lat, lo, ex;
    always #12.5 aclk = ~aclk;
    // Response channels are always ready, which the bus allows
    cdb_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .cmp_a_out(ca), .cmp_b_out(cb), .cmp_c_out(cc),
        .cmp_a_irq(irqv[0]), .cmp_b_irq(irqv[1]), .cmp_c_irq(irqv[2]),
        .analog_ctl(actl), .irq(irq));
    cdb_cmp_model partner (.aclk(aclk), .want(want), .slow(slow), .cmp_a_out(ca),
        .cmp_b_out(cb), .cmp_c_out(cc));
    //====================================================
    // Reporting
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // A wait that ran out ends the run as a failure
    task automatic guard;
        if (n >= 50) begin
            fails++;
            give_verdict();
        end
    endtask : guard
    //====================================================
    // Bus cycles, entered just after a rising edge
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        logic ad, wdn;
        ad = 1'b0;
        wdn = 1'b0;
        n = 0;
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // Each half is released at the edge that takes it
        while (!(ad && wdn) && n < 50) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wdn = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge aclk);
            n++;
        end while (!bvalid && n < 50);
        rs = bresp;
        guard();
    endtask : wr
    task automatic rdr(input logic [4:0] a);
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (!arready && n < 50);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (!rvalid && n < 50);
        rd = rdata;
        rs = rresp;
        guard();
    endtask : rdr
    // Raise one comparator and count edges until its interrupt signal follows
    task automatic meas(input int i, output int c);
        want[i] <= 1'b1;
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (irqv[i] !== 1'b1 && c < 300);
        want[i] <= 1'b0;
        repeat (40) @(posedge aclk);
    endtask : meas
    // Blanking delay in aclk cycles: five per step, saturating at 48 steps
    function automatic int blank_cyc(input logic [5:0] code);
        return ((code > 6'd48) ? 48 : int'(code)) * 5;
    endfunction : blank_cyc
    //====================================================
    // Main sequence
    initial begin
        void'($urandom(32270));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            rdr(5'(k * 4));
            chk("reset value", 32'h0, rd);
        end
        // Random register contents, read back and seen on the analog side
        d = 8'($urandom);
        e = 8'($urandom);
        wr(CDB_OFS_HYST, d);
        wr(CDB_OFS_DAC, e);
        chk("write resp", 32'(CDB_RESP_OK), 32'(rs));
        rdr(CDB_OFS_HYST);
        chk("hysteresis", {28'h0, d[3:0]}, rd);
        rdr(CDB_OFS_DAC);
        chk("dac code", {24'h0, e}, rd);
        chk("analog ctl", {20'h0, e, d[3:0]}, 32'(actl));
        rdr(5'h02);
        chk("unmapped resp", 32'(CDB_RESP_DECERR), 32'(rs));
        wr(CDB_OFS_CEN, 8'h0F);
        wr(CDB_OFS_MASK, 8'h07);
        // Filter off: two synchroniser flops and nothing more
        meas(0, lat);
        chk("unfiltered latency", 32'h1, 32'(lat <= 3));
        chk("irq raised", 32'h1, 32'(irq));
        wr(CDB_OFS_MASK, 8'h00);
        chk("irq masked", 32'h0, 32'(irq));
        wr(CDB_OFS_MASK, 8'h07);
        wr(CDB_OFS_STAT, 8'h07);
        chk("irq cleared", 32'h0, 32'(irq));
        // Clock enable low: the synchroniser must not move
        ce <= 1'b0;
        want[0] <= 1'b1;
        repeat (20) @(posedge aclk);
        chk("frozen irq a", 32'h0, 32'(irqv[0]));
        want[0] <= 1'b0;
        ce <= 1'b1;
        repeat (5) @(posedge aclk);
        // Filters on with the outputs low: no event; short glitches are swallowed
        wr(CDB_OFS_FILT, 8'hE0);
        want <= 3'h7;
        repeat ($urandom_range(4, 2)) @(posedge aclk);
        want <= 3'h0;
        repeat (30) @(posedge aclk);
        rdr(CDB_OFS_STAT);
        chk("glitch status", 32'h0, rd);
        slow <= 1'b1;
        meas(0, lat);
        slow <= 1'b0;
        chk("filtered latency", 32'h1, 32'(lat >= 12 && lat <= 24));
        meas(1, lat);
        chk("filtered latency b", 32'h1, 32'(lat >= 12 && lat <= 24));
        wr(CDB_OFS_STAT, 8'h07);
        // Changing the filter setting while the output is high raises the event
        want[0] <= 1'b1;
        repeat (30) @(posedge aclk);
        wr(CDB_OFS_STAT, 8'h07);
        wr(CDB_OFS_FILT, 8'h00);
        rdr(CDB_OFS_STAT);
        chk("setting change event", 32'h1, rd);
        want[0] <= 1'b0;
        repeat (10) @(posedge aclk);
        wr(CDB_OFS_STAT, 8'h07);
        // A disabled comparator reads low whatever its pin shows
        wr(CDB_OFS_CEN, 8'h0D);
        want[0] <= 1'b1;
        repeat (30) @(posedge aclk);
        chk("disabled irq a", 32'h0, 32'(irqv[0]));
        want[0] <= 1'b0;
        wr(CDB_OFS_CEN, 8'h0F);
        // Blanking delay on comparator c against the direct path
        meas(2, l0);
        codes = '{6'h00, 6'h01, 6'h02, 6'h2F, 6'h30, 6'h3F, 6'($urandom_range(46, 3))};
        foreach (codes[k]) begin
            wr(CDB_OFS_LEB, {2'b11, codes[k]});
            meas(2, lat);
            ex = blank_cyc(codes[k]);
            lo = (ex == 0) ? 0 : ex - 5;
            chk("blank delay", 32'h1, 32'(lat - l0 >= lo && lat - l0 <= ex + 1));
        end
        wr(CDB_OFS_LEB, 8'hBF);
        meas(2, lat);
        chk("direct source", 32'(l0), 32'(lat));
        wr(CDB_OFS_LEB, 8'h41);
        meas(2, lat);
        chk("valley not started", 32'd300, 32'(lat));
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire

/* verilog/cdb_blank.sv */
// Leading-edge blanking delay for the valley detection path
`timescale 1ns/1ps
`default_nettype none
module cdb_blank
    import cdb_pkg::*;
#(
    parameter int STEP_CYC = CDB_LEB_STEP_CYC,
    parameter int SAT_STEPS = CDB_LEB_SAT_STEPS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire cdb_leb_t ctl,
    input wire logic din, // Filtered comparator c level
    output logic dout // valley_detect_out
);

    logic [5:0] steps; // Effective step count after saturation
    logic [7:0] total; // Blanking length in system cycles
    logic [7:0] cnt_r; // Remaining blanking cycles

    //==============================================================
    // Saturate codes 11xxxx
    always_comb begin
        steps = ctl.blanking_delay_code;
        if (ctl.blanking_delay_code[5:4] == 2'b11) begin
            steps = 6'(SAT_STEPS);
        end
        total = 8'(steps * STEP_CYC);
    end

    //==============================================================
    // Blanking counter: reloaded while the signal is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 8'h00;
        end else if (ce) begin
            if (!din || !ctl.valley_detect_start) begin
                cnt_r <= total;
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end

    // Code zero skips the counter entirely
    assign dout = ctl.valley_detect_start && din
                  && (ctl.blanking_delay_code == 6'h00 || cnt_r == 8'h00);

endmodule : cdb_blank
`default_nettype wire

/* verilog/cdb_filter.sv */
// Debounce filter for one comparator output
`timescale 1ns/1ps
`default_nettype none
module cdb_filter
    import cdb_pkg::*;
#(
    parameter int PERIODS = CDB_DBC_PERIODS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic tick, // Debounce clock tick
    input wire logic filter_en,
    input wire logic din, // Synchronised, enable-gated comparator level
    output logic dout
);

    logic filt_r; // Accepted stable level
    logic [2:0] cnt_r; // Ticks seen with input differing

    //==============================================================
    // Stability counter
    // Tracks the input even while disabled, so enabling never glitches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_r <= 1'b0;
            cnt_r <= 3'h0;
        end else if (ce) begin
            if (!filter_en || din == filt_r) begin
                // Follow directly, restart window
                filt_r <= din;
                cnt_r <= 3'h0;
            end else if (tick) begin
                // Phase of first tick is random: 2 to 3 debounce periods
                if (cnt_r == 3'(PERIODS - 1)) begin
                    filt_r <= din;
                    cnt_r <= 3'h0;
                end else begin
                    cnt_r <= cnt_r + 3'h1;
                end
            end
        end
    end

    // Bypass path adds no cycle when filtering is off
    assign dout = filter_en ? filt_r : din;

endmodule : cdb_filter
`default_nettype wire

/* verilog/cdb_top.sv */
// Comparator debounce, hysteresis, DAC code and blanking with AXI4-Lite registers
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cdb_top
    import cdb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite slave
    input wire logic [CDB_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [CDB_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Raw comparator outputs from the analog side
    input wire logic cmp_a_out,
    input wire logic cmp_b_out,
    input wire logic cmp_c_out,
    // Conditioned interrupt signals
    output logic cmp_a_irq,
    output logic cmp_b_irq,
    output logic cmp_c_irq,
    // Analog controls and summary interrupt
    output var cdb_analog_t analog_ctl,
    output logic irq
);

    //==============================================================
    // Register storage
    logic [2:0] filt_en_r; // a, b, c debounce enables
    logic [3:0] hyst_r; // z, a, b, c hysteresis
    logic [7:0] dac_r; // Reference DAC code
    cdb_leb_t leb_r; // Blanking control
    logic [3:0] cen_r; // Comparator enables, bit n is comparator n
    logic [2:0] stat_r; // Sticky events a, b, c
    logic [2:0] mask_r; // Interrupt mask

    //==============================================================
    // Bus handshake state
    logic aw_held_r;
    logic w_held_r;
    logic [CDB_ADDR_W-1:0] awaddr_r;
    logic [7:0] wbyte_r;
    logic wstrb0_r;
    logic wr_go; // Both halves of a write present
    logic [CDB_ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_lane;
    logic wr_hit; // Address decodes to a register
    logic [31:0] rd_mux;
    logic rd_hit;

    //==============================================================
    // Signal path
    logic [2:0] pin_meta_r; // First synchroniser stage
    logic [2:0] pin_sync_r; // Second stage, the only reader of the first
    logic [2:0] cmp_lvl; // Enable-gated comparator levels
    logic [2:0] cmp_dbc; // Straight out of the debounce filter
    logic [2:0] cmp_filt; // After the debounce filter, forced low while disabled
    logic [2:0] irq_sig; // Interrupt path per comparator
    logic [2:0] irq_sig_d_r; // For edge detection
    logic [2:0] chg_evt; // Debounce setting changed while high
    logic valley_detect_out;
    logic [2:0] tick_div_r;
    logic tick;

    //==============================================================
    // Debounce clock tick, one cycle in five
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_div_r <= 3'h0;
        end else if (ce) begin
            tick_div_r <= (tick_div_r == 3'(CDB_DBC_DIV - 1)) ? 3'h0 : tick_div_r + 3'h1;
        end
    end
    assign tick = (tick_div_r == 3'(CDB_DBC_DIV - 1));

    //==============================================================
    // Per-comparator synchroniser, gating and filter
    genvar gi;
    generate
        for (gi = 0; gi < CDB_NCMP; gi++) begin : g_cmp
            // Pins are asynchronous to aclk
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_meta_r[gi] <= 1'b0;
                    pin_sync_r[gi] <= 1'b0;
                end else if (ce) begin
                    pin_meta_r[gi] <= (gi == 0) ? cmp_a_out : (gi == 1) ? cmp_b_out : cmp_c_out;
                    pin_sync_r[gi] <= pin_meta_r[gi];
                end
            end
            // Disabled comparator reads low
            assign cmp_lvl[gi] = pin_sync_r[gi] & cen_r[gi + 1];
            cdb_filter u_filt (
                .aclk(aclk),
                .aresetn(aresetn),
                .ce(ce),
                .tick(tick),
                .filter_en(filt_en_r[gi]),
                .din(cmp_lvl[gi]),
                .dout(cmp_dbc[gi])
            );
            // Filter may still hold a high level after a disable, so gate it again
            assign cmp_filt[gi] = cmp_dbc[gi] & cen_r[gi + 1];
            // A write that flips this enable while the output is high raises the event
            assign chg_evt[gi] = wr_go && wr_lane && wr_addr == CDB_OFS_FILT
                                 && wr_data[CDB_FILT_LSB + gi] != filt_en_r[gi]
                                 && irq_sig[gi];
        end
    endgenerate

    // Valley detection with leading-edge blanking
    cdb_blank u_blank (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .ctl(leb_r),
        .din(cmp_filt[2]),
        .dout(valley_detect_out)
    );

    assign irq_sig[0] = cmp_filt[0];
    assign irq_sig[1] = cmp_filt[1];
    assign irq_sig[2] = leb_r.cmp_c_irq_source_sel ? valley_detect_out : cmp_filt[2];
    assign cmp_a_irq = irq_sig[0];
    assign cmp_b_irq = irq_sig[1];
    assign cmp_c_irq = irq_sig[2];

    //==============================================================
    // AXI write channel capture: address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wbyte_r <= 8'h00;
            wstrb0_r <= 1'b0;
        end else if (ce) begin
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_r <= 1'b1;
                    awaddr_r <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_r <= 1'b1;
                    wbyte_r <= s_axi_wdata[7:0];
                    wstrb0_r <= s_axi_wstrb[0];
                end
            end
        end
    end

    // Held response blocks new writes until bready
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign wr_go = (aw_held_r || (s_axi_awvalid && s_axi_awready))
                   && (w_held_r || (s_axi_wvalid && s_axi_wready));
    assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
    assign wr_data = w_held_r ? wbyte_r : s_axi_wdata[7:0];
    assign wr_lane = w_held_r ? wstrb0_r : s_axi_wstrb[0];
    assign wr_hit = (wr_addr[1:0] == 2'b00) && (wr_addr <= CDB_OFS_LIVE);

    //==============================================================
    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CDB_RESP_OK;
        end else if (ce) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? CDB_RESP_OK : CDB_RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    //==============================================================
    // Control registers, byte lane 0 only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_en_r <= 3'h0;
            hyst_r <= 4'h0;
            dac_r <= CDB_RST_BYTE;
            leb_r <= cdb_leb_t'(CDB_RST_BYTE);
            cen_r <= 4'h0;
            mask_r <= 3'h0;
        end else if (ce && wr_go && wr_lane) begin
            case (wr_addr)
                CDB_OFS_FILT: filt_en_r <= wr_data[CDB_FILT_LSB +: CDB_NCMP];
                CDB_OFS_HYST: hyst_r <= wr_data[3:0];
                CDB_OFS_DAC: dac_r <= wr_data;
                CDB_OFS_LEB: leb_r <= cdb_leb_t'(wr_data);
                CDB_OFS_CEN: cen_r <= wr_data[3:0];
                CDB_OFS_MASK: mask_r <= wr_data[2:0];
                default: ; // Status and live are handled elsewhere or read-only
            endcase
        end
    end

    //==============================================================
    // Sticky status: rising interrupt signal or a risky filter change
    // Set wins over the write-one clear of the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_r <= 3'h0;
            irq_sig_d_r <= 3'h0;
        end else if (ce) begin
            irq_sig_d_r <= irq_sig;
            stat_r <= (stat_r & ~((wr_go && wr_lane && wr_addr == CDB_OFS_STAT)
                                  ? wr_data[2:0] : 3'h0))
                      | (irq_sig & ~irq_sig_d_r) | chg_evt;
        end
    end

    // Level interrupt, high while any unmasked bit is set
    assign irq = |(stat_r & mask_r);

    //==============================================================
    // Read path
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            CDB_OFS_FILT: rd_mux[CDB_FILT_LSB +: CDB_NCMP] = filt_en_r;
            CDB_OFS_HYST: rd_mux[3:0] = hyst_r;
            CDB_OFS_DAC: rd_mux[7:0] = dac_r;
            CDB_OFS_LEB: rd_mux[7:0] = leb_r;
            CDB_OFS_CEN: rd_mux[3:0] = cen_r;
            CDB_OFS_STAT: rd_mux[2:0] = stat_r;
            CDB_OFS_MASK: rd_mux[2:0] = mask_r;
            CDB_OFS_LIVE: rd_mux[3:0] = {valley_detect_out, irq_sig[2], irq_sig[1], irq_sig[0]};
            default: rd_hit = 1'b0; // Unmapped reads zero with an error
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    // Read data registered, one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= CDB_RESP_OK;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? CDB_RESP_OK : CDB_RESP_DECERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign analog_ctl = {dac_r, hyst_r};

    //==============================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_FILT_LOW_OFF: assert property (!cen_r[1] |-> !cmp_a_irq)
        else $error("comparator a signal high while disabled");
    AST_HYST_WR: assert property (ce && wr_go && wr_lane && wr_addr == CDB_OFS_HYST
        |=> analog_ctl[3:0] == $past(wr_data[3:0]))
        else $error("hysteresis enables not taken from write");
    AST_DAC_WR: assert property (ce && wr_go && wr_lane && wr_addr == CDB_OFS_DAC
        |=> analog_ctl.cmp3_reference_dac_code == $past(wr_data))
        else $error("DAC code not taken from write");
    AST_SRC_SEL: assert property (cmp_c_irq == (leb_r.cmp_c_irq_source_sel
        ? valley_detect_out : cmp_filt[2]))
        else $error("comparator c interrupt source wrong");
    AST_VALLEY_OFF: assert property (!leb_r.valley_detect_start |-> !valley_detect_out)
        else $error("valley output while detection stopped");
    AST_BYPASS: assert property (leb_r.valley_detect_start
        && leb_r.blanking_delay_code == 6'h00 |-> valley_detect_out == cmp_filt[2])
        else $error("zero delay code did not bypass");
    AST_BLANK_MIN: assert property (ce && $rose(cmp_filt[2]) && leb_r.valley_detect_start
        && leb_r.blanking_delay_code != 6'h00 |-> !valley_detect_out)
        else $error("blanking did not hold off the leading edge");
    AST_CHG_EVT: assert property (ce && chg_evt[0] |=> stat_r[0])
        else $error("filter change with output high lost its event");
    AST_BYPASS_FILT: assert property (!filt_en_r[0] |-> cmp_a_irq == cmp_lvl[0])
        else $error("unfiltered path delayed");
    AST_DBC_STABLE: assert property (ce && filt_en_r[1] && $rose(cmp_b_irq)
        |-> $past(cmp_lvl[1], 1) && $past(cmp_lvl[1], 2))
        else $error("debounced output rose on a short pulse");

    CV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
    CV_READ: cover property (s_axi_rvalid && s_axi_rready);
    CV_VALLEY: cover property (valley_detect_out && leb_r.blanking_delay_code != 6'h00);
    CV_IRQ: cover property ($rose(irq));

endmodule : cdb_top
`default_nettype wire
